// ---- verilog/acrb_pkg.sv ----
package acrb_pkg;
	// register bank shape
	localparam int REG_COUNT = 4;
	localparam int REG_W = 8;
	localparam int ADDR_W = 2;
	// register offsets
	localparam logic [1:0] OFS_INPUT_GAIN = 2'h0;
	localparam logic [1:0] OFS_RATE_MODE = 2'h1;
	localparam logic [1:0] OFS_STATUS_INTEGRITY = 2'h2;
	localparam logic [1:0] OFS_CURRENT_ROUTE = 2'h3;
	// reset values, all zero
	localparam logic [7:0] RST_VALUE = 8'h00;
	// host-writable bits per register
	localparam logic [7:0] WMASK_INPUT_GAIN = 8'hff;
	localparam logic [7:0] WMASK_RATE_MODE = 8'hff;
	localparam logic [7:0] WMASK_STATUS_INTEGRITY = 8'h7f;
	localparam logic [7:0] WMASK_CURRENT_ROUTE = 8'hfc;
	// input_gain_config fields
	localparam int INSEL_MSB = 7;
	localparam int INSEL_LSB = 4;
	localparam int GAIN_MSB = 3;
	localparam int GAIN_LSB = 1;
	localparam int BYPASS_BIT = 0;
	// rate_mode_config fields
	localparam int RATE_MSB = 7;
	localparam int RATE_LSB = 5;
	localparam int OPMODE_BIT = 4;
	localparam int CONV_BIT = 3;
	localparam int REF_MSB = 2;
	localparam int REF_LSB = 1;
	localparam int TEMP_BIT = 0;
	// status_integrity_config fields
	localparam int READY_BIT = 7;
	localparam int CNT_BIT = 6;
	localparam int INTEG_MSB = 5;
	localparam int INTEG_LSB = 4;
	localparam int BURN_BIT = 3;
	localparam int EXC_MSB = 2;
	localparam int EXC_LSB = 0;
	// current_route_config fields
	localparam int ROUTE1_MSB = 7;
	localparam int ROUTE1_LSB = 5;
	localparam int ROUTE2_MSB = 4;
	localparam int ROUTE2_LSB = 2;
	// command byte layout
	localparam int OP_MSB = 7;
	localparam int OP_LSB = 4;
	localparam int RR_MSB = 3;
	localparam int RR_LSB = 2;
	localparam logic [3:0] OP_READ_REGISTER = 4'h2;
	localparam logic [3:0] OP_WRITE_REGISTER = 4'h4;
	// serial byte framing
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam int SLV_ADDR_W = 7;
	// link state, gray along the usual path
	typedef enum logic [2:0] {
		ACRB_L_IDLE = 3'b000,
		ACRB_L_ADDR = 3'b001,
		ACRB_L_ADDR_ACK = 3'b011,
		ACRB_L_RX = 3'b010,
		ACRB_L_RX_ACK = 3'b110,
		ACRB_L_TX = 3'b111,
		ACRB_L_TX_ACK = 3'b101
	} acrb_link_e;
	// command decoder state
	typedef enum logic [1:0] {
		ACRB_C_IDLE = 2'b00,
		ACRB_C_CMD = 2'b01,
		ACRB_C_DATA = 2'b11
	} acrb_cmd_e;
endpackage

// ---- verilog/acrb_byte_if.sv ----
`timescale 1ns/1ps
interface acrb_byte_if;
	logic frame_start; // start or repeated start pulse
	logic frame_stop; // stop pulse
	logic rx_valid; // one byte received in a write frame
	logic [7:0] rx_byte; // received byte
	logic rd_req; // next read byte wanted
	logic [7:0] tx_byte; // byte to send in read frame
	// serial side
	modport link (output frame_start, frame_stop, rx_valid, rx_byte, rd_req, input tx_byte);
	// command side
	modport core (input frame_start, frame_stop, rx_valid, rx_byte, rd_req, output tx_byte);
endinterface

// ---- verilog/acrb_i2c_link.sv ----
`timescale 1ns/1ps
module acrb_i2c_link (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [6:0] slave_addr_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_oe_n_o,
	acrb_byte_if.link bus
);
	acrb_pkg::acrb_link_e state, next_state; // link state
	logic scl_q, sda_q; // previous pin levels
	logic [7:0] shift, next_shift; // serial shift register
	logic [3:0] cnt, next_cnt; // bit counter
	logic rw, next_rw; // read frame flag
	logic drive, next_drive; // pulling sda low
	logic start_p, stop_p, rx_p, rd_p; // next pulse values
	logic start_q, stop_q, rx_q, rd_q; // registered pulses
	logic scl_rise, scl_fall, start_det, stop_det;

	// pin edge and condition detect
	assign scl_rise = scl_i & ~scl_q;
	assign scl_fall = ~scl_i & scl_q;
	assign start_det = scl_i & scl_q & sda_q & ~sda_i;
	assign stop_det = scl_i & scl_q & ~sda_q & sda_i;

	// next-state logic of the byte engine
	always_comb begin
		next_state = state;
		next_shift = shift;
		next_cnt = cnt;
		next_rw = rw;
		next_drive = drive;
		start_p = 1'b0;
		stop_p = 1'b0;
		rx_p = 1'b0;
		rd_p = 1'b0;
		if (stop_det) begin
			// stop ends everything
			next_state = acrb_pkg::ACRB_L_IDLE;
			next_drive = 1'b0;
			stop_p = 1'b1;
		end else if (start_det) begin
			// start or repeated start
			next_state = acrb_pkg::ACRB_L_ADDR;
			next_cnt = 4'h0;
			next_drive = 1'b0;
			start_p = 1'b1;
		end else begin
			case (state)
				acrb_pkg::ACRB_L_ADDR: begin
					if (scl_rise) begin
						next_shift = {shift[6:0], sda_i};
						next_cnt = cnt + 4'h1;
					end else if (scl_fall && cnt == acrb_pkg::BYTE_BITS) begin
						if (shift[7:1] == slave_addr_i) begin
							// matched: acknowledge
							next_rw = shift[0];
							next_drive = 1'b1;
							next_state = acrb_pkg::ACRB_L_ADDR_ACK;
							rd_p = shift[0];
						end else begin
							next_state = acrb_pkg::ACRB_L_IDLE;
						end
					end
				end
				acrb_pkg::ACRB_L_ADDR_ACK, acrb_pkg::ACRB_L_RX_ACK: begin
					if (scl_fall) begin
						next_cnt = 4'h0;
						if (rw) begin
							// first data bit of read byte
							next_shift = bus.tx_byte;
							next_drive = ~bus.tx_byte[7];
							next_state = acrb_pkg::ACRB_L_TX;
						end else begin
							next_drive = 1'b0;
							next_state = acrb_pkg::ACRB_L_RX;
						end
					end
				end
				acrb_pkg::ACRB_L_RX: begin
					if (scl_rise) begin
						next_shift = {shift[6:0], sda_i};
						next_cnt = cnt + 4'h1;
					end else if (scl_fall && cnt == acrb_pkg::BYTE_BITS) begin
						// byte done: hand over, acknowledge
						rx_p = 1'b1;
						next_drive = 1'b1;
						next_state = acrb_pkg::ACRB_L_RX_ACK;
					end
				end
				acrb_pkg::ACRB_L_TX: begin
					if (scl_fall) begin
						next_cnt = cnt + 4'h1;
						if (cnt + 4'h1 == acrb_pkg::BYTE_BITS) begin
							// release for host acknowledge
							next_drive = 1'b0;
							next_state = acrb_pkg::ACRB_L_TX_ACK;
						end else begin
							next_shift = {shift[6:0], 1'b0};
							next_drive = ~shift[6];
						end
					end
				end
				acrb_pkg::ACRB_L_TX_ACK: begin
					if (scl_rise) begin
						if (sda_i) begin
							// host nack: wait for stop
							next_state = acrb_pkg::ACRB_L_IDLE;
						end else begin
							rd_p = 1'b1;
						end
					end else if (scl_fall) begin
						next_cnt = 4'h0;
						next_shift = bus.tx_byte;
						next_drive = ~bus.tx_byte[7];
						next_state = acrb_pkg::ACRB_L_TX;
					end
				end
				default: begin
					next_state = acrb_pkg::ACRB_L_IDLE;
					next_drive = 1'b0;
				end
			endcase
		end
	end

	// link registers
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= acrb_pkg::ACRB_L_IDLE;
			shift <= 8'h00;
			cnt <= 4'h0;
			rw <= 1'b0;
			drive <= 1'b0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			start_q <= 1'b0;
			stop_q <= 1'b0;
			rx_q <= 1'b0;
			rd_q <= 1'b0;
		end else begin
			state <= next_state;
			shift <= next_shift;
			cnt <= next_cnt;
			rw <= next_rw;
			drive <= next_drive;
			scl_q <= scl_i;
			sda_q <= sda_i;
			start_q <= start_p;
			stop_q <= stop_p;
			rx_q <= rx_p;
			rd_q <= rd_p;
		end
	end

	// outputs
	assign sda_oe_n_o = ~drive;
	assign bus.frame_start = start_q;
	assign bus.frame_stop = stop_q;
	assign bus.rx_valid = rx_q;
	assign bus.rx_byte = shift;
	assign bus.rd_req = rd_q;
endmodule

// ---- verilog/acrb_reg_bank.sv ----
`timescale 1ns/1ps
// Behaviour
// - four byte registers, reached by register commands
// - reset loads every register with zero
// - power-down keeps all register values
// - fields of registers 00h and 01h
// - fields of 02h and 03h, 03h low bits zero
// - register 00h fully read-write, resets zero
// - read-only and read-write access classes
// - read command selects byte for next read frame
// - chained writes, each restarts filter and conversion
// - new result sets data ready flag
module acrb_reg_bank (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [6:0] slave_addr_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire logic powerdown_i,
	input wire logic conv_ready_i,
	input wire logic data_read_i,
	output logic [3:0] input_selector_o,
	output logic [2:0] gain_select_o,
	output logic amp_bypass_o,
	output logic [2:0] rate_select_o,
	output logic operating_mode_o,
	output logic conv_mode_o,
	output logic [1:0] ref_select_o,
	output logic temp_sensor_en_o,
	output logic data_ready_flag_o,
	output logic counter_en_o,
	output logic [1:0] integrity_mode_o,
	output logic burnout_en_o,
	output logic [2:0] excite_current_o,
	output logic [2:0] current1_route_o,
	output logic [2:0] current2_route_o,
	output logic filter_restart_o
);
	acrb_byte_if bus (); // link to command path

	// storage and its next values, one byte per register
	// kept as an array so the write path is one loop, not four copies
	logic [7:0] cfg [acrb_pkg::REG_COUNT]; // register storage
	logic [7:0] next_cfg [acrb_pkg::REG_COUNT];
	logic [7:0] wmask [acrb_pkg::REG_COUNT]; // writable bits per register
	acrb_pkg::acrb_cmd_e cstate, next_cstate; // command decoder state
	logic [1:0] wr_addr, next_wr_addr; // target of pending write
	logic [1:0] rd_addr, next_rd_addr; // register chosen for read
	logic [7:0] tx, next_tx; // byte offered to the link
	logic restart, next_restart; // filter restart pulse
	logic [3:0] opcode; // command high nibble
	logic [1:0] cmd_rr; // command register address

	// serial engine: bit timing, start and stop detection, acknowledge
	// the link only moves bytes; it knows nothing of commands or registers
	// its handshake pulses are registered, so the decoder sees them one clock late
	// a host must therefore leave several clocks in every scl phase
	// scl is taken as synchronous, so its levels are not filtered here
	acrb_i2c_link link (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.slave_addr_i(slave_addr_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_oe_n_o(sda_oe_n_o),
		.bus(bus)
	);

	// writable masks; ready flag read-only, 03h low bits fixed
	// bits outside a mask keep their old value on a host write
	assign wmask[acrb_pkg::OFS_INPUT_GAIN] = acrb_pkg::WMASK_INPUT_GAIN;
	assign wmask[acrb_pkg::OFS_RATE_MODE] = acrb_pkg::WMASK_RATE_MODE;
	assign wmask[acrb_pkg::OFS_STATUS_INTEGRITY] = acrb_pkg::WMASK_STATUS_INTEGRITY;
	assign wmask[acrb_pkg::OFS_CURRENT_ROUTE] = acrb_pkg::WMASK_CURRENT_ROUTE;

	// command byte split
	// only the opcode nibble and register address matter; low two bits ignored
	assign opcode = bus.rx_byte[acrb_pkg::OP_MSB:acrb_pkg::OP_LSB];
	assign cmd_rr = bus.rx_byte[acrb_pkg::RR_MSB:acrb_pkg::RR_LSB];

	// command decoder next values
	// a start always re-arms the decoder, so a frame begins with a command
	// a write command waits for exactly one data byte, then a command again
	// a write command cut off by stop or repeated start is dropped
	// unknown opcodes are acked by the link but change nothing here
	// stop is tested first, so a stop always leaves the decoder idle
	always_comb begin
		next_cstate = cstate;
		next_wr_addr = wr_addr;
		next_rd_addr = rd_addr;
		next_restart = 1'b0;
		if (bus.frame_stop) begin
			// stop closes any chain
			next_cstate = acrb_pkg::ACRB_C_IDLE;
		end else if (bus.frame_start) begin
			// each frame opens with a command
			next_cstate = acrb_pkg::ACRB_C_CMD;
		end else if (bus.rx_valid) begin
			case (cstate)
				acrb_pkg::ACRB_C_CMD: begin
					// command byte: only two opcodes are decoded
					if (opcode == acrb_pkg::OP_WRITE_REGISTER) begin
						// remember the target, wait for its data byte
						next_wr_addr = cmd_rr;
						next_cstate = acrb_pkg::ACRB_C_DATA;
					end else if (opcode == acrb_pkg::OP_READ_REGISTER) begin
						// select the byte for the next read frame
						next_rd_addr = cmd_rr;
					end
				end
				acrb_pkg::ACRB_C_DATA: begin
					// data byte taken; next command may follow
					next_restart = 1'b1;
					next_cstate = acrb_pkg::ACRB_C_CMD;
				end
				default: begin
					// idle: bytes outside an addressed frame are ignored
					next_cstate = acrb_pkg::ACRB_C_IDLE;
				end
			endcase
		end
	end

	// register next values; commands and the ready flag inputs change them
	// storage has no power-down input on purpose: contents simply hold
	// the mask keeps read-only and fixed bits out of host writes
	// the ready flag is the only bit that hardware sets and someone clears
	// set is applied after clear, so a result in the clearing cycle is kept
	always_comb begin
		for (int i = 0; i < acrb_pkg::REG_COUNT; i++) begin
			next_cfg[i] = cfg[i];
			if (bus.rx_valid && cstate == acrb_pkg::ACRB_C_DATA &&
				wr_addr == i[1:0]) begin
				// masked host write
				next_cfg[i] = (cfg[i] & ~wmask[i]) | (bus.rx_byte & wmask[i]);
			end
		end
		// ready flag: clear on data read, new result wins
		if (data_read_i) begin
			next_cfg[acrb_pkg::OFS_STATUS_INTEGRITY][acrb_pkg::READY_BIT] = 1'b0;
		end
		if (conv_ready_i) begin
			next_cfg[acrb_pkg::OFS_STATUS_INTEGRITY][acrb_pkg::READY_BIT] = 1'b1;
		end
	end

	// read byte offered to link
	// captured when the read address matches and again at each host acknowledge
	// a byte is a snapshot: a flag set mid-byte shows in the next byte
	// the chosen register stays selected until the next read command
	always_comb begin
		next_tx = tx;
		if (bus.rd_req) begin
			next_tx = cfg[rd_addr];
		end
	end

	// one storage flop group per register
	// reset and power-up both land here; every register starts at zero
	// reset is asynchronous, so fields drop at once, not at the next edge
	// the ready flag clears with the rest, so no stale result survives
	for (genvar g = 0; g < acrb_pkg::REG_COUNT; g++) begin : g_reg
		always_ff @(posedge clk_i or posedge rst_i) begin
			if (rst_i) begin
				cfg[g] <= acrb_pkg::RST_VALUE;
			end else begin
				cfg[g] <= next_cfg[g];
			end
		end
	end

	// decoder and read path registers
	// pending addresses point at the first register after reset
	// restart is a one-clock pulse, low again unless another write lands
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cstate <= acrb_pkg::ACRB_C_IDLE;
			wr_addr <= acrb_pkg::OFS_INPUT_GAIN;
			rd_addr <= acrb_pkg::OFS_INPUT_GAIN;
			tx <= acrb_pkg::RST_VALUE;
			restart <= 1'b0;
		end else begin
			cstate <= next_cstate;
			wr_addr <= next_wr_addr;
			rd_addr <= next_rd_addr;
			tx <= next_tx;
			restart <= next_restart;
		end
	end

	// byte for the link comes from a flop, never from live storage
	assign bus.tx_byte = tx;
	// open drain: only ever pulls low
	// the enable does the work; a released line rises by its pull-up
	assign sda_o = 1'b0;
	// one pulse per data byte written, even when the value is unchanged
	// this restarts the filter and any conversion in progress
	assign filter_restart_o = restart;

	// field outputs, straight from storage
	// they change one clock after the clock that sees scl fall
	// behind the last bit of a data byte
	assign input_selector_o = cfg[acrb_pkg::OFS_INPUT_GAIN][acrb_pkg::INSEL_MSB:acrb_pkg::INSEL_LSB];
	assign gain_select_o = cfg[acrb_pkg::OFS_INPUT_GAIN][acrb_pkg::GAIN_MSB:acrb_pkg::GAIN_LSB];
	assign amp_bypass_o = cfg[acrb_pkg::OFS_INPUT_GAIN][acrb_pkg::BYPASS_BIT];
	assign rate_select_o = cfg[acrb_pkg::OFS_RATE_MODE][acrb_pkg::RATE_MSB:acrb_pkg::RATE_LSB];
	assign operating_mode_o = cfg[acrb_pkg::OFS_RATE_MODE][acrb_pkg::OPMODE_BIT];
	assign conv_mode_o = cfg[acrb_pkg::OFS_RATE_MODE][acrb_pkg::CONV_BIT];
	assign ref_select_o = cfg[acrb_pkg::OFS_RATE_MODE][acrb_pkg::REF_MSB:acrb_pkg::REF_LSB];
	assign temp_sensor_en_o = cfg[acrb_pkg::OFS_RATE_MODE][acrb_pkg::TEMP_BIT];
	assign data_ready_flag_o = cfg[acrb_pkg::OFS_STATUS_INTEGRITY][acrb_pkg::READY_BIT];
	assign counter_en_o = cfg[acrb_pkg::OFS_STATUS_INTEGRITY][acrb_pkg::CNT_BIT];
	assign integrity_mode_o =
		cfg[acrb_pkg::OFS_STATUS_INTEGRITY][acrb_pkg::INTEG_MSB:acrb_pkg::INTEG_LSB];
	assign burnout_en_o = cfg[acrb_pkg::OFS_STATUS_INTEGRITY][acrb_pkg::BURN_BIT];
	assign excite_current_o =
		cfg[acrb_pkg::OFS_STATUS_INTEGRITY][acrb_pkg::EXC_MSB:acrb_pkg::EXC_LSB];
	assign current1_route_o =
		cfg[acrb_pkg::OFS_CURRENT_ROUTE][acrb_pkg::ROUTE1_MSB:acrb_pkg::ROUTE1_LSB];
	assign current2_route_o =
		cfg[acrb_pkg::OFS_CURRENT_ROUTE][acrb_pkg::ROUTE2_MSB:acrb_pkg::ROUTE2_LSB];
endmodule

// ---- testbench/acrb_i2c_host.sv ----
`timescale 1ns/1ps
// host model: drives scl and a released-high sda, samples the wired sda
module acrb_i2c_host (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	// bus idles high
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// third of an scl bit period, changes land on falling clk edges
	task automatic phase();
		repeat (4) @(negedge clk_i);
	endtask
	// start or repeated start: sda falls while scl high
	task automatic start();
		sda_o = 1'b1;
		phase();
		scl_o = 1'b1;
		phase();
		sda_o = 1'b0;
		phase();
		scl_o = 1'b0;
		phase();
	endtask
	// stop: sda rises while scl high
	task automatic stop();
		sda_o = 1'b0;
		phase();
		scl_o = 1'b1;
		phase();
		sda_o = 1'b1;
		phase();
	endtask
	// one bit: data set while scl low, sampled while scl high
	task automatic bitx(input logic b, output logic r);
		sda_o = b;
		phase();
		scl_o = 1'b1;
		phase();
		r = sda_i;
		scl_o = 1'b0;
		phase();
	endtask
	// byte msb first, then ack bit; ai high releases sda
	task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
		output logic ao);
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], q[i]);
		end
		bitx(ai, ao);
	endtask
endmodule

// ---- testbench/acrb_reg_bank_sva.sv ----
`timescale 1ns/1ps
// pin-level checks on the register bank
module acrb_reg_bank_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_oe_n_o,
	input wire logic powerdown_i,
	input wire logic conv_ready_i,
	input wire logic data_read_i,
	input wire logic [3:0] input_selector_o,
	input wire logic amp_bypass_o,
	input wire logic [2:0] rate_select_o,
	input wire logic [2:0] excite_current_o,
	input wire logic [2:0] current2_route_o,
	input wire logic data_ready_flag_o,
	input wire logic filter_restart_o
);
	// sample of host-written fields from all four registers
	wire logic [13:0] cfg = {input_selector_o, amp_bypass_o, rate_select_o, excite_current_o,
		current2_route_o};
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_rst_zero;
		$fell(rst_i) |-> cfg == 14'h0000 && !data_ready_flag_o && sda_oe_n_o;
	endproperty
	a_rst_zero: assert property (p_rst_zero) else $error("fields not zero after reset");
	property p_flag_set;
		conv_ready_i |=> data_ready_flag_o;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("ready flag not set");
	property p_flag_clr;
		data_read_i && !conv_ready_i |=> !data_ready_flag_o;
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("ready flag not cleared");
	property p_flag_hold;
		$fell(data_ready_flag_o) |-> $past(data_read_i);
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("ready flag dropped alone");
	property p_cfg_restart;
		$changed(cfg) |-> filter_restart_o;
	endproperty
	a_cfg_restart: assert property (p_cfg_restart) else $error("write without restart");
	property p_restart_pulse;
		filter_restart_o |=> !filter_restart_o;
	endproperty
	a_restart_pulse: assert property (p_restart_pulse) else $error("restart too long");
	property p_pd_keep;
		$changed(powerdown_i) |=> $stable(cfg);
	endproperty
	a_pd_keep: assert property (p_pd_keep) else $error("power-down changed fields");
	property p_sda_hold;
		scl_i && $past(scl_i) |-> $stable(sda_oe_n_o);
	endproperty
	a_sda_hold: assert property (p_sda_hold) else $error("sda moved with scl high");
endmodule
bind acrb_reg_bank acrb_reg_bank_sva sva_u (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.scl_i(scl_i),
	.sda_oe_n_o(sda_oe_n_o),
	.powerdown_i(powerdown_i),
	.conv_ready_i(conv_ready_i),
	.data_read_i(data_read_i),
	.input_selector_o(input_selector_o),
	.amp_bypass_o(amp_bypass_o),
	.rate_select_o(rate_select_o),
	.excite_current_o(excite_current_o),
	.current2_route_o(current2_route_o),
	.data_ready_flag_o(data_ready_flag_o),
	.filter_restart_o(filter_restart_o)
);

// ---- testbench/acrb_reg_bank_tb_top.sv ----
`timescale 1ns/1ps
// register commands through the host model, checked against expected bytes
module acrb_reg_bank_tb_top;
	localparam logic [6:0] SLV = 7'h45; // bus address, arbitrary
	logic clk_i, rst_i, powerdown_i, conv_ready_i, data_read_i, ack;
	wire logic scl, sda_h, sda_o, sda_oe_n_o, filter_restart_o;
	wire logic sda_w = sda_h & (sda_oe_n_o | sda_o); // open drain with pull-up
	wire [31:0] fields; // register bytes 00h..03h as seen on the field pins
	int bad_count, n_checks, cyc, pulses;
	logic [7:0] q;
	logic [7:0] wm [4] = '{8'hff, 8'hff, 8'h7f, 8'hfc}; // writable bits per register
	assign fields[1:0] = 2'h0;
	acrb_i2c_host h_u (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_h));
	acrb_reg_bank dut_u (.clk_i(clk_i), .rst_i(rst_i), .slave_addr_i(SLV), .scl_i(scl),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .powerdown_i(powerdown_i),
		.conv_ready_i(conv_ready_i), .data_read_i(data_read_i),
		.input_selector_o(fields[31:28]), .gain_select_o(fields[27:25]),
		.amp_bypass_o(fields[24]), .rate_select_o(fields[23:21]),
		.operating_mode_o(fields[20]), .conv_mode_o(fields[19]), .ref_select_o(fields[18:17]),
		.temp_sensor_en_o(fields[16]), .data_ready_flag_o(fields[15]),
		.counter_en_o(fields[14]), .integrity_mode_o(fields[13:12]),
		.burnout_en_o(fields[11]), .excite_current_o(fields[10:8]),
		.current1_route_o(fields[7:5]), .current2_route_o(fields[4:2]),
		.filter_restart_o(filter_restart_o));
	// 25 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	// restart pulse count and hang guard, sampled away from the launching edge
	always @(negedge clk_i) begin
		cyc++;
		if (filter_restart_o === 1'b1) pulses++;
		if (cyc == 40000) begin
			bad_count++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one byte of a write frame, device must ack
	task automatic send(input logic [7:0] b);
		logic [7:0] r;
		logic a;
		h_u.xfer(b, 1'b1, r, a);
		check("ack", {31'h0, a}, 32'h0);
	endtask
	task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
		h_u.start();
		send({SLV, 1'b0});
		send({acrb_pkg::OP_WRITE_REGISTER, a, 2'h0});
		send(d);
		h_u.stop();
	endtask
	// read command in a write frame, then byte back in a read frame
	task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
		logic k;
		h_u.start();
		send({SLV, 1'b0});
		send({acrb_pkg::OP_READ_REGISTER, a, 2'h0});
		h_u.start();
		send({SLV, 1'b1});
		h_u.xfer(8'hff, 1'b1, d, k);
		h_u.stop();
	endtask
	initial begin
		rst_i = 1'b1;
		powerdown_i = 1'b0;
		conv_ready_i = 1'b0;
		data_read_i = 1'b0;
		repeat (12) @(posedge clk_i);
		@(negedge clk_i);
		rst_i = 1'b0;
		check("fields", fields, 32'h0);
		for (int a = 0; a < 4; a++) begin
			rd_reg(a[1:0], q);
			check("reset byte", {24'h0, q}, 32'h0);
		end
		for (int a = 0; a < 4; a++) begin
			wr_reg(a[1:0], 8'hff);
		end
		for (int a = 0; a < 4; a++) begin
			rd_reg(a[1:0], q);
			check("rw byte", {24'h0, q}, {24'h0, wm[a]});
		end
		check("fields", fields, 32'hffff7ffc);
		// two writes chained in one frame
		pulses = 0;
		h_u.start();
		send({SLV, 1'b0});
		send(8'h40);
		send(8'h5a);
		send(8'h44);
		send(8'ha5);
		h_u.stop();
		check("restarts", pulses, 32'h2);
		check("fields", fields, 32'h5aa57ffc);
		// unknown opcode ignored, write cut off by stop dropped
		pulses = 0;
		h_u.start();
		send({SLV, 1'b0});
		send(8'h8c);
		send(8'h4c);
		h_u.stop();
		check("no restart", pulses, 32'h0);
		check("fields", fields, 32'h5aa57ffc);
		// foreign bus address is not acked
		h_u.start();
		h_u.xfer({SLV ^ 7'h01, 1'b0}, 1'b1, q, ack);
		h_u.stop();
		check("nack", {31'h0, ack}, 32'h1);
		// power-down keeps contents
		@(negedge clk_i);
		powerdown_i = 1'b1;
		repeat (50) @(negedge clk_i);
		powerdown_i = 1'b0;
		rd_reg(2'h0, q);
		check("pd byte", {24'h0, q}, 32'h5a);
		check("pd fields", fields, 32'h5aa57ffc);
		// new result sets flag, readout clears it
		@(negedge clk_i);
		conv_ready_i = 1'b1;
		@(negedge clk_i);
		conv_ready_i = 1'b0;
		check("flag", {31'h0, fields[15]}, 32'h1);
		rd_reg(2'h2, q);
		check("flag byte", {24'h0, q}, 32'hff);
		@(negedge clk_i);
		data_read_i = 1'b1;
		@(negedge clk_i);
		data_read_i = 1'b0;
		check("flag", {31'h0, fields[15]}, 32'h0);
		// new result and clear in one cycle: the result wins
		@(negedge clk_i);
		conv_ready_i = 1'b1;
		data_read_i = 1'b1;
		@(negedge clk_i);
		conv_ready_i = 1'b0;
		data_read_i = 1'b0;
		check("flag both", {31'h0, fields[15]}, 32'h1);
		// reset in mid-run clears everything
		rst_i = 1'b1;
		@(negedge clk_i);
		check("fields", fields, 32'h0);
		rst_i = 1'b0;
		rd_reg(2'h0, q);
		check("reset byte", {24'h0, q}, 32'h0);
		report_and_stop();
	end
endmodule
